// File: bitmap_lcd_refresh_core_tb.sv
`timescale 1ns/1ps
module bitmap_lcd_refresh_core_tb;
   import blrc_pkg::*;
   // stimulus
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic fclk = 1'b0;
   logic sel_a = 1'b0;
   logic sel_b = 1'b0;
   // observed outputs
   blrc_cmd_s cmd;
   blrc_pwr_s pwr_en;
   logic [7:0] rd_data, contrast, v;
   logic busy, icon, frame, tick;
   logic [95:0] segs;
   logic [15:0] rows;
   // bench model state
   int fails = 0;
   int checked = 0;
   int n, pg, col;
   logic [31:0] seed = 32'hD018B4F1;
   logic [7:0] ram_m [3][112]; // expected bytes, page by column

   blrc_core u_dut (.clk(clk), .reset_n(reset_n), .fundamental_clock_in(fclk), .cmd(cmd), .rd_data(rd_data),
      .busy_indicator(busy), .power_mode_sel_a(sel_a), .power_mode_sel_b(sel_b), .pwr_en(pwr_en),
      .contrast_level_register(contrast), .column_drive_out(segs), .row_drive_out(rows),
      .icon_row_drive(icon), .frame_alternation_signal(frame), .line_rate_tick(tick));
   blrc_host_model u_host (.clk(clk), .busy_indicator(busy), .rd_data(rd_data), .cmd(cmd));

   // 50 ns clock
   initial
   begin
      forever #25 clk = ~clk;
   end
   // fundamental clock at half rate, so one line is 768 bench cycles
   always @(posedge clk) fclk <= #2 ~fclk;

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic wrap_up();
      if (fails == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
      checked++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #2;
   endtask
   // next line tick; m is the spacing from the previous return, 4 cycles of settling included
   task automatic wait_tick(output int m);
      m = 0;
      do
      begin
         cyc(1);
         m++;
      end
      while (tick !== 1'b1 && m < 1000);
      if (m >= 1000)
      begin
         fails++;
         wrap_up();
      end
      cyc(4);
      m += 4;
   endtask
   // sync to a frame wrap, then follow every common slot of one frame
   task automatic frame_check(input int lines, input bit rev, input bit icon_en);
      logic start_phase;
      start_phase = frame;
      for (int i = 0; i < 20 && frame === start_phase; i++)
         wait_tick(n);
      for (int k = 0; k < lines; k++)
      begin
         if (k > 0)
            wait_tick(n);
         if (k > 0)
            chk("tick spacing", 768, n);
         chk("rows", (k < 16) ? 96'h1 << (rev ? 15 - k : k) : 96'h0, rows);
         chk("icon row", icon_en && k == 16, icon);
         chk("frame", !start_phase, frame);
      end
      wait_tick(n);
      chk("frame wrap", start_phase, frame);
      chk("line zero", rev ? 96'h8000 : 96'h1, rows);
   endtask
   task automatic set_at(input int p, input int c);
      pg = p;
      col = c;
      u_host.send(BLRC_OP_SET_PAGE, 8'(p));
      u_host.send(BLRC_OP_SET_COLUMN, 8'(c));
   endtask
   // page two keeps only bit 0
   task automatic wr(input logic [7:0] d);
      ram_m[pg][col] = (pg == 2) ? {7'h00, d[0]} : d;
      col++;
      u_host.send(BLRC_OP_DATA_WRITE, d);
   endtask
   task automatic rd_chk(input int p, input int c, input int k);
      logic [7:0] r;
      set_at(p, c);
      for (int i = 0; i < k; i++)
      begin
         u_host.read(BLRC_OP_DATA_READ, r);
         chk("ram byte", (p == 2) ? ram_m[p][c + i][0] : ram_m[p][c + i], (p == 2) ? r[0] : r);
      end
   endtask

   initial
   begin
      cyc(4);
      reset_n = 1'b1;
      u_host.read(BLRC_OP_STATUS_READ, v);
      chk("busy status", 1, v[7]);
      u_host.send(BLRC_OP_CONTRAST, 8'h5A, 1'b1);
      u_host.send(BLRC_OP_NOP, 8'h00);
      u_host.read(BLRC_OP_STATUS_READ, v);
      chk("reset status", 8'h00, v);
      chk("contrast", 8'h00, contrast);
      chk("power", 3'h0, pwr_en);
      v = 8'(xs());
      u_host.send(BLRC_OP_CONTRAST, v);
      chk("contrast", v, contrast);
      // every strap combination, then all stages off together
      for (int i = 0; i < 4; i++)
      begin
         sel_a = i[0];
         sel_b = i[1];
         u_host.send(BLRC_OP_POWER, 8'h01);
         cyc(1);
         chk("power on", {!sel_a, !(sel_a && sel_b), 1'b1}, pwr_en);
      end
      u_host.send(BLRC_OP_POWER, 8'h00);
      cyc(1);
      chk("power off", 3'h0, pwr_en);
      // uniform blank ram so every row and shift gives the same segments
      for (int p = 0; p < 3; p++)
      begin
         set_at(p, 0);
         for (int c = 0; c < 112; c++)
            wr((p == 2) ? 8'(xs()) & 8'hFE : 8'h00);
      end
      u_host.send(BLRC_OP_DISPLAY, 8'h01);
      u_host.send(BLRC_OP_ICON, 8'h01);
      frame_check(17, 1'b0, 1'b1);
      chk("segs normal", 96'h0, segs);
      u_host.send(BLRC_OP_INVERSE, 8'h01);
      repeat (3) wait_tick(n);
      chk("segs inverse", {96{1'b1}}, segs);
      u_host.send(BLRC_OP_DISPLAY, 8'h00);
      repeat (3) wait_tick(n);
      chk("segs off", 96'h0, segs);
      u_host.send(BLRC_OP_ROW_ORDER, 8'h08);
      frame_check(17, 1'b1, 1'b1);
      u_host.send(BLRC_OP_DUTY, 8'h00);
      frame_check(16, 1'b1, 1'b1);
      u_host.send(BLRC_OP_ADC, 8'h01);
      u_host.read(BLRC_OP_STATUS_READ, v);
      chk("adc status", 8'h40, v);
      u_host.send(BLRC_OP_ADC, 8'h00);
      // page change leaves the column where it was
      set_at(0, 8'h6D);
      wr(8'(xs()));
      wr(8'(xs()));
      u_host.send(BLRC_OP_SET_PAGE, 8'h01);
      pg = 1;
      wr(8'(xs()));
      set_at(2, 8'h10);
      wr(8'(xs()));
      // second reset in mid run
      reset_n = 1'b0;
      cyc(200);
      reset_n = 1'b1;
      n = 0;
      while (busy !== 1'b0 && n < 100)
      begin
         cyc(1);
         n++;
      end
      chk("recovery", 1, n >= 20 && n <= 21);
      u_host.read(BLRC_OP_STATUS_READ, v);
      chk("status after reset", 8'h00, v);
      chk("contrast after reset", 8'h00, contrast);
      rd_chk(0, 8'h6D, 2);
      rd_chk(1, 8'h6E, 2);
      rd_chk(2, 8'h10, 1);
      // mirrored column 6A lands on ram column 5; a scroll of 3 brings it to segment 2
      u_host.send(BLRC_OP_ADC, 8'h01);
      set_at(0, 8'h6A);
      wr(8'hFF);
      set_at(1, 8'h6A);
      wr(8'hFF);
      u_host.send(BLRC_OP_SCROLL, 8'h83);
      u_host.send(BLRC_OP_DISPLAY, 8'h01);
      // two ticks flush the preload and the display latch; stay off the icon slot and the last common
      repeat (2) wait_tick(n);
      for (int i = 0; i < 3 && (rows === 16'h0000 || rows[15] !== 1'b0); i++)
         wait_tick(n);
      chk("segs scroll", 96'h1 << (8'h6F - 8'h6A - 3), segs);
      wait_tick(n);
      chk("segs next line", 96'h1 << (8'h6F - 8'h6A - 3), segs);
      wrap_up();
   end
endmodule

// File: blrc_core.sv
// How it works
// (RULE_01) busy high blocks all but status read
// (RULE_02) status read puts busy on bit 7
// (RULE_03) line counter clears on frame toggle, advances
// (RULE_04) column counter increments, saturates at A0
// (RULE_05) host keeps accesses at column 6F or below
// (RULE_06) page register leaves column counter alone
// (RULE_07) column reversal mirrors column decode
// (RULE_08) page two is icon row, bit 0
// (RULE_09) inverse mode swaps pixel polarity
// (RULE_10) one 112-bit row read per line
// (RULE_11) refresh reads ram independent of host
// (RULE_12) row order bit reverses sixteen commons
// (RULE_13) icon common in slot seventeen when enabled
// (RULE_14) reset loads listed default settings
// (RULE_15) reset held 10us, resume after 1us
// (RULE_16) reset spares ram and read data outputs
// (RULE_17) line latch preloads next line each period
// (RULE_18) on/off and static act on latch only
// (RULE_19) scroll shifts up to 15 toward segment zero
// (RULE_20) display latch holds 96 shifted bits
// (RULE_21) line tick is fundamental clock over 384
// (RULE_22) frame signal alternates every frame
// (RULE_23) power off kills all stages together
// (RULE_24) line counter wraps after selected duty
`timescale 1ns/1ps
`include "blrc_defines.svh"
module blrc_core
   import blrc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // fundamental display clock, sampled on clk
   input wire logic fundamental_clock_in,
   // decoded host instruction port
   input wire blrc_cmd_s cmd,
   output logic [7:0] rd_data,
   output logic busy_indicator,
   // power mode straps
   input wire logic power_mode_sel_a,
   input wire logic power_mode_sel_b,
   output blrc_pwr_s pwr_en,
   output logic [7:0] contrast_level_register,
   // panel drive
   output logic [95:0] column_drive_out,
   output logic [15:0] row_drive_out,
   output logic icon_row_drive,
   output logic frame_alternation_signal,
   output logic line_rate_tick
);
   blrc_state_s q; // registered state
   blrc_state_s d; // next state
   logic fedge; // rising edge of the fundamental clock
   logic accept; // instruction taken this cycle
   logic [4:0] nxt_line; // line after the current one
   logic [4:0] pre_line; // line after nxt_line
   logic [6:0] phys_col; // ram column after mirroring
   logic [111:0] shifted; // pre latch after scroll shift

   // wrap a line index at the selected duty
   function automatic logic [4:0] blrc_step(input logic [4:0] ln, input logic d17);
      logic [4:0] last;
      last = d17 ? `BLRC_LAST_LINE_17 : `BLRC_LAST_LINE_16;
      blrc_step = (ln >= last) ? 5'h00 : ln + 5'h01;
   endfunction

   // all next-state logic; host port and refresh path share one process
   always_comb
   begin
      d = q;
      d.tick = 1'b0;
      d.fclk_prev = fundamental_clock_in;
      fedge = fundamental_clock_in & ~q.fclk_prev;
      nxt_line = blrc_step(q.line, q.duty17);
      pre_line = blrc_step(nxt_line, q.duty17);
      // mirrored decode, so reversal costs nothing on the refresh side
      phys_col = q.adc ? (7'h6F - q.col[6:0]) : q.col[6:0]; // see RULE_07
      shifted = q.scroll_on ? (q.pre_latch >> q.scroll_shift) : q.pre_latch; // see RULE_19
      // only status reads pass while busy
      accept = cmd.valid & ((q.recover == 5'h00) | (cmd.op == BLRC_OP_STATUS_READ)); // see RULE_01

      // display clock divider on fundamental clock edges
      if (fedge)
      begin
         if (q.div == 9'(`BLRC_LINE_DIV - 1))
         begin
            d.div = 9'h000;
            d.tick = 1'b1; // see RULE_21
         end
         else
         begin
            d.div = q.div + 9'h001;
         end
      end

      // refresh path: reads ram on its own, never waits on the host
      if (q.tick)
      begin
         d.line = nxt_line; // see RULE_03
         if (nxt_line == 5'h00)
         begin
            d.frame = ~q.frame; // see RULE_22, RULE_24
         end
         d.seg_latch = shifted[95:0]; // see RULE_20
         d.pre_latch = q.ram[pre_line]; // see RULE_10, RULE_11, RULE_17
      end

      // on/off, static and polarity touch the latched copy only
      if (!q.disp_on)
      begin
         d.seg_out = '0; // see RULE_18
      end
      else if (q.static_on)
      begin
         d.seg_out = '1;
      end
      else
      begin
         d.seg_out = q.inverse ? ~q.seg_latch : q.seg_latch; // see RULE_09
      end

      // common scan, forward or reversed
      for (int k = 0; k < `BLRC_COM_COUNT; k++)
      begin
         d.rows[q.row_order ? (15 - k) : k] = (d.line == 5'(k)); // see RULE_12
      end
      d.icon_out = q.icon_on & (d.line == `BLRC_ICON_LINE); // see RULE_13

      // reset recovery countdown
      if (q.recover != 5'h00)
      begin
         d.recover = q.recover - 5'h01;
      end

      // host instructions
      if (accept)
      begin
         case (cmd.op)
            BLRC_OP_STATUS_READ:
            begin
               d.rd_data = 8'h00;
               d.rd_data[`BLRC_STAT_BUSY_BIT] = (q.recover != 5'h00); // see RULE_02
               d.rd_data[`BLRC_STAT_ADC_BIT] = q.adc;
               d.rd_data[`BLRC_STAT_ON_BIT] = q.disp_on;
            end
            BLRC_OP_DATA_WRITE:
            begin
               // columns past 6F are never stored
               if (q.col <= `BLRC_COL_LAST)
               begin
                  if (q.page == `BLRC_ICON_PAGE)
                  begin
                     d.ram[`BLRC_ICON_LINE][phys_col] = cmd.data[0]; // see RULE_08
                  end
                  else if (q.page != 2'h3)
                  begin
                     for (int b = 0; b < 8; b++)
                     begin
                        d.ram[{q.page[0], 3'(b)}][phys_col] = cmd.data[b];
                     end
                  end
               end
               if (q.col != `BLRC_COL_STOP)
               begin
                  d.col = q.col + 8'h01; // see RULE_04
               end
            end
            BLRC_OP_DATA_READ:
            begin
               d.rd_data = 8'h00;
               if (q.page == `BLRC_ICON_PAGE)
               begin
                  d.rd_data[0] = q.ram[`BLRC_ICON_LINE][phys_col];
               end
               else
               begin
                  for (int b = 0; b < 8; b++)
                  begin
                     d.rd_data[b] = q.ram[{q.page[0], 3'(b)}][phys_col];
                  end
               end
               // read-modify-write holds the column so the following write lands on it
               if ((q.col != `BLRC_COL_STOP) && !q.rmw)
               begin
                  d.col = q.col + 8'h01; // see RULE_04
               end
            end
            BLRC_OP_SET_COLUMN:
            begin
               d.col = cmd.data;
            end
            BLRC_OP_SET_PAGE:
            begin
               d.page = cmd.data[1:0]; // see RULE_06
            end
            BLRC_OP_DISPLAY:
            begin
               d.disp_on = cmd.data[0];
            end
            BLRC_OP_INVERSE:
            begin
               d.inverse = cmd.data[0];
            end
            BLRC_OP_ADC:
            begin
               d.adc = cmd.data[0];
            end
            BLRC_OP_ICON:
            begin
               d.icon_on = cmd.data[0];
            end
            BLRC_OP_STATIC:
            begin
               d.static_on = cmd.data[0];
            end
            BLRC_OP_ROW_ORDER:
            begin
               d.row_order = cmd.data[3];
            end
            BLRC_OP_CONTRAST:
            begin
               d.contrast = cmd.data;
            end
            BLRC_OP_SCROLL:
            begin
               d.scroll_on = cmd.data[7];
               d.scroll_mode16 = cmd.data[6];
               d.scroll_speed = cmd.data[6:4] & 3'h7;
               d.scroll_shift = cmd.data[3:0];
            end
            BLRC_OP_POWER:
            begin
               d.pwr_on = cmd.data[0];
            end
            BLRC_OP_DUTY:
            begin
               d.duty17 = cmd.data[0];
            end
            BLRC_OP_RMW:
            begin
               d.rmw = cmd.data[0];
            end
            BLRC_OP_SOFT_RESET:
            begin
               d.col = `BLRC_COL_RESET;
               d.page = `BLRC_PAGE_RESET;
               d.contrast = `BLRC_CONTRAST_RESET;
            end
            default:
            begin
               d.rd_data = q.rd_data;
            end
         endcase
      end

      // step-up and regulator follow the straps, follower does not; off drops all three at once
      d.pwr.step_up_en = d.pwr_on & ~power_mode_sel_a; // see RULE_23
      d.pwr.regulator_en = d.pwr_on & ~(power_mode_sel_a & power_mode_sel_b);
      d.pwr.follower_en = d.pwr_on;

      // reset rewrites settings, line, frame, divider and drive outputs; ram, the two latches and read data are kept
      if (!reset_n)
      begin
         d.disp_on = 1'b0; // see RULE_14, RULE_16
         d.inverse = 1'b0;
         d.icon_on = 1'b0;
         d.adc = 1'b0;
         d.rmw = 1'b0;
         d.pwr_on = 1'b0;
         d.pwr = '0;
         d.serial_reg = 8'h00;
         d.col = `BLRC_COL_RESET;
         d.page = `BLRC_PAGE_RESET;
         d.row_order = 1'b0;
         d.contrast = `BLRC_CONTRAST_RESET;
         d.scroll_on = 1'b0;
         d.scroll_mode16 = 1'b0;
         d.scroll_speed = `BLRC_SCROLL_SPEED_RESET;
         d.scroll_shift = 4'h0;
         d.scroll_pages = 8'h00;
         d.static_on = 1'b0;
         d.duty17 = 1'b1;
         d.line = 5'h00;
         d.frame = 1'b0;
         d.div = 9'h000;
         d.tick = 1'b0;
         d.seg_out = '0;
         d.rows = '0;
         d.icon_out = 1'b0;
         d.recover = 5'(`BLRC_RECOVER_CYC); // see RULE_15
      end
   end

   // single state register
   always_ff @(posedge clk)
   begin
      q <= d;
   end

   // outputs straight from flops; busy is decoded from the recovery count
   assign rd_data = q.rd_data;
   assign busy_indicator = (q.recover != 5'h00);
   assign pwr_en = q.pwr;
   assign contrast_level_register = q.contrast;
   assign column_drive_out = q.seg_out;
   assign row_drive_out = q.rows;
   assign icon_row_drive = q.icon_out;
   assign frame_alternation_signal = q.frame;
   assign line_rate_tick = q.tick;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // after release busy stands for at least the first eight cycles of recovery
   sequence s_release;
      $rose(reset_n);
   endsequence
   property p_busy_recover;
      s_release |-> busy_indicator [*8];
   endproperty
   a_busy_recover: assert property (p_busy_recover) else $error("busy dropped early after reset"); // see RULE_15

   property p_busy_blocks;
      (busy_indicator && cmd.valid && cmd.op != BLRC_OP_STATUS_READ) |=> ($stable(q.col) && $stable(q.contrast));
   endproperty
   a_busy_blocks: assert property (p_busy_blocks) else $error("instruction taken while busy"); // see RULE_01

   property p_status_bit7;
      (cmd.valid && cmd.op == BLRC_OP_STATUS_READ) |=> rd_data[7] == $past(busy_indicator);
   endproperty
   a_status_bit7: assert property (p_status_bit7) else $error("status bit 7 not busy"); // see RULE_02

   property p_col_inc;
      (!busy_indicator && cmd.valid && cmd.op == BLRC_OP_DATA_WRITE && q.col < `BLRC_COL_STOP)
         |=> q.col == $past(q.col) + 8'h01;
   endproperty
   a_col_inc: assert property (p_col_inc) else $error("column did not advance"); // see RULE_04

   property p_col_sat;
      (q.col == `BLRC_COL_STOP && !(cmd.valid && (cmd.op == BLRC_OP_SET_COLUMN || cmd.op == BLRC_OP_SOFT_RESET)))
         |=> q.col == `BLRC_COL_STOP;
   endproperty
   a_col_sat: assert property (p_col_sat) else $error("column passed stop value"); // see RULE_04

   property p_page_col;
      (cmd.valid && cmd.op == BLRC_OP_SET_PAGE) |=> $stable(q.col);
   endproperty
   a_page_col: assert property (p_page_col) else $error("page set moved column"); // see RULE_06

   property p_frame_wrap;
      $changed(frame_alternation_signal) |-> q.line == 5'h00;
   endproperty
   a_frame_wrap: assert property (p_frame_wrap) else $error("frame toggled off line zero"); // see RULE_03

   property p_tick_div;
      line_rate_tick |-> q.div == 9'h000;
   endproperty
   a_tick_div: assert property (p_tick_div) else $error("line tick off divider wrap"); // see RULE_21

   property p_pwr_off;
      !q.pwr_on |-> pwr_en == '0;
   endproperty
   a_pwr_off: assert property (p_pwr_off) else $error("power stage on while off"); // see RULE_23

   property p_icon;
      icon_row_drive |-> (q.icon_on && q.line == `BLRC_ICON_LINE && row_drive_out == '0);
   endproperty
   a_icon: assert property (p_icon) else $error("icon common out of slot"); // see RULE_13

   property p_blank;
      !q.disp_on |=> column_drive_out == '0;
   endproperty
   a_blank: assert property (p_blank) else $error("segments lit while off"); // see RULE_18
endmodule

// File: blrc_defines.svh
`ifndef BLRC_DEFINES_SVH
`define BLRC_DEFINES_SVH
// clock and timing figures
`define BLRC_CLK_PERIOD_NS 50
`define BLRC_RECOVER_NS 1000
`define BLRC_RECOVER_CYC ((`BLRC_RECOVER_NS + `BLRC_CLK_PERIOD_NS - 1) / `BLRC_CLK_PERIOD_NS)
`define BLRC_RESET_HOLD_US 10
`define BLRC_RESET_HOLD_CYC ((`BLRC_RESET_HOLD_US * 1000 + `BLRC_CLK_PERIOD_NS - 1) / `BLRC_CLK_PERIOD_NS)
`define BLRC_LINE_DIV 384
// column counter limits
`define BLRC_COL_STOP 8'hA0
`define BLRC_COL_LAST 8'h6F
`define BLRC_COL_RESET 8'h00
// ram shape
`define BLRC_RAM_ROWS 17
`define BLRC_RAM_COLS 112
`define BLRC_SEG_COUNT 96
`define BLRC_COM_COUNT 16
`define BLRC_ICON_PAGE 2'h2
`define BLRC_ICON_LINE 5'h10
`define BLRC_LAST_LINE_16 5'h0F
`define BLRC_LAST_LINE_17 5'h10
// register reset values
`define BLRC_PAGE_RESET 2'h0
`define BLRC_CONTRAST_RESET 8'h00
`define BLRC_SCROLL_SPEED_RESET 3'h4
// status byte layout
`define BLRC_STAT_BUSY_BIT 7
`define BLRC_STAT_ADC_BIT 6
`define BLRC_STAT_ON_BIT 5
`endif

// File: blrc_host_model.sv
`timescale 1ns/1ps
module blrc_host_model
   import blrc_pkg::*;
(
   // clock and answers from the core
   input wire logic clk,
   input wire logic busy_indicator,
   input wire logic [7:0] rd_data,
   // instruction port
   output blrc_cmd_s cmd
);
   logic [7:0] col_m; // column the host believes is current
   initial
   begin
      cmd = '0;
      col_m = 8'h00;
   end
   // one instruction, valid for one cycle; careless skips the busy wait on purpose
   task automatic send(input blrc_op_e op, input logic [7:0] data, input bit careless = 1'b0);
      int n;
      @(posedge clk);
      #2;
      n = 0;
      // bounded wait, so a stuck busy cannot hang the host
      while (!careless && op != BLRC_OP_STATUS_READ && busy_indicator !== 1'b0 && n < 100)
      begin
         @(posedge clk);
         #2;
         n++;
      end
      // a busy that never drops is a failure of the core, not a reason to wait on
      if (n >= 100)
      begin
         bitmap_lcd_refresh_core_tb.fails++;
         bitmap_lcd_refresh_core_tb.wrap_up();
      end
      if (op == BLRC_OP_SET_COLUMN)
         col_m = data;
      // past the last real column the host stays away from ram
      if ((op == BLRC_OP_DATA_WRITE || op == BLRC_OP_DATA_READ) && col_m > 8'h6F)
         return;
      if (op == BLRC_OP_DATA_WRITE || op == BLRC_OP_DATA_READ)
         col_m++;
      cmd = '{1'b1, op, data};
      @(posedge clk);
      #2;
      cmd.valid = 1'b0;
   endtask
   // read or status: answer is taken one cycle after the taken edge
   task automatic read(input blrc_op_e op, output logic [7:0] val);
      send(op, 8'h00);
      @(posedge clk);
      #2;
      val = rd_data;
   endtask
endmodule

// File: blrc_pkg.sv
package blrc_pkg;
   // decoded host instruction kinds
   typedef enum logic [4:0] {
      BLRC_OP_NOP = 5'h00,
      BLRC_OP_STATUS_READ = 5'h01,
      BLRC_OP_DATA_WRITE = 5'h02,
      BLRC_OP_DATA_READ = 5'h03,
      BLRC_OP_SET_COLUMN = 5'h04,
      BLRC_OP_SET_PAGE = 5'h05,
      BLRC_OP_DISPLAY = 5'h06,
      BLRC_OP_INVERSE = 5'h07,
      BLRC_OP_ADC = 5'h08,
      BLRC_OP_ICON = 5'h09,
      BLRC_OP_STATIC = 5'h0A,
      BLRC_OP_ROW_ORDER = 5'h0B,
      BLRC_OP_CONTRAST = 5'h0C,
      BLRC_OP_SCROLL = 5'h0D,
      BLRC_OP_POWER = 5'h0E,
      BLRC_OP_DUTY = 5'h0F,
      BLRC_OP_RMW = 5'h10,
      BLRC_OP_SOFT_RESET = 5'h11
   } blrc_op_e;
   // one host instruction, valid for one cycle
   typedef struct packed {
      logic valid;
      blrc_op_e op;
      logic [7:0] data;
   } blrc_cmd_s;
   // power stage enables
   typedef struct packed {
      logic step_up_en;
      logic regulator_en;
      logic follower_en;
   } blrc_pwr_s;
   // whole block state
   typedef struct packed {
      logic [16:0][111:0] ram;
      logic [111:0] pre_latch;
      logic [95:0] seg_latch;
      logic [95:0] seg_out;
      logic [15:0] rows;
      logic icon_out;
      logic [8:0] div;
      logic fclk_prev;
      logic tick;
      logic [4:0] line;
      logic frame;
      logic [7:0] col;
      logic [1:0] page;
      logic [7:0] rd_data;
      logic [4:0] recover;
      logic disp_on;
      logic inverse;
      logic icon_on;
      logic adc;
      logic rmw;
      logic static_on;
      logic row_order;
      logic duty17;
      logic [7:0] contrast;
      logic scroll_on;
      logic scroll_mode16;
      logic [2:0] scroll_speed;
      logic [3:0] scroll_shift;
      logic [7:0] scroll_pages;
      logic [7:0] serial_reg;
      logic pwr_on;
      blrc_pwr_s pwr;
   } blrc_state_s;
endpackage
